//--- hw/alu_pkg.sv
// Package for the 8-bit add, subtract and AND datapath.
// Assumes a single 100 MHz clock domain shared by all users.
package alu_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int ALU_CLK_NS = 10;
   // Indexed forms: five machine cycles of 4,4,3,5,3 clock states.
   localparam int ALU_IDX_MCYC = 5;
   localparam int ALU_IDX_TSTATES = 19;
   localparam logic [4:0] ALU_IDX_LAST = 5'h12;
   localparam logic [2:0] ALU_DIR_LAST = 3'h3;
   localparam logic [2:0] ALU_MEM_LAST = 3'h6;
   // ****************************************************************
   // Opcodes
   // ****************************************************************
   localparam logic [7:0] ALU_PFX_FIRST = 8'hdd;
   localparam logic [7:0] ALU_PFX_SECOND = 8'hfd;
   localparam logic [7:0] ALU_MEM_MASK = 8'hc7;
   localparam logic [7:0] ALU_MEM_PAT = 8'h86;
   localparam logic [7:0] ALU_IMM_PAT = 8'hc6;
   localparam logic [1:0] ALU_REG_TOP = 2'h2;
   localparam logic [2:0] ALU_FLD_MEM = 3'h6;
   localparam logic [2:0] ALU_FLD_ACC = 3'h7;
   localparam logic [2:0] ALU_GRP_ADD = 3'h0;
   localparam logic [2:0] ALU_GRP_ADC = 3'h1;
   localparam logic [2:0] ALU_GRP_SUB = 3'h2;
   localparam logic [2:0] ALU_GRP_SBC = 3'h3;
   localparam logic [2:0] ALU_GRP_AND = 3'h4;
   localparam int ALU_NREG = 8;
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      ALU_SRC_REG, ALU_SRC_IMM, ALU_SRC_PAIR, ALU_SRC_IDX
   } alu_src_e;
   typedef struct packed {
      logic sign;
      logic zero;
      logic half;
      logic parOvf;
      logic subtract;
      logic carry;
   } alu_flags_s;
   localparam alu_flags_s ALU_FLAGS_RST = '0;
   localparam logic [7:0] ALU_ACC_RST = 8'h00;
endpackage

//--- hw/alu_regfile.sv
// Eight-entry byte register file for the datapath operands.
// Assumes the main datapath writes one entry per cycle.
`timescale 1ns/1ps
module alu_regfile import alu_pkg::*; #(
   parameter int DEPTH = ALU_NREG
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic wrEn,
   input wire logic [2:0] wrSel,
   input wire logic [7:0] wrData,
   input wire logic [2:0] rdSel,
   output logic [7:0] rdData
);
   logic [7:0] mem [DEPTH];
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : gEntry
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               mem[g] <= 8'h00;
            end else if (clkEn && wrEn && wrSel == 3'(g)) begin
               mem[g] <= wrData;
            end
         end
      end
   endgenerate
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdData <= 8'h00;
      end else if (clkEn) begin
         rdData <= mem[rdSel];
      end
   end
endmodule

//--- hw/alu_core.sv
// Top of the 8-bit add, subtract and AND datapath with flags.
// Assumes the decoder presents one instruction at a time and memory answers
// a read within the cycle in which memRd is high.
`timescale 1ns/1ps
module alu_core import alu_pkg::*; #(
   parameter int ADDR_W = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic start,
   input wire logic [7:0] prefix,
   input wire logic [7:0] opcode,
   input wire logic [7:0] operandByte,
   input wire logic [ADDR_W-1:0] address_pair,
   input wire logic [ADDR_W-1:0] first_index_register,
   input wire logic [ADDR_W-1:0] second_index_register,
   input wire logic [7:0] memData,
   input wire logic regWrEn,
   input wire logic [2:0] regWrSel,
   input wire logic [7:0] regWrData,
   output logic busy,
   output logic done,
   output logic illegal,
   output logic memRd,
   output logic [ADDR_W-1:0] memAddr,
   output logic [7:0] acc,
   output alu_flags_s flags
);
   // ****************************************************************
   // Decode
   // ****************************************************************
   typedef enum {ST_IDLE, ST_WAIT, ST_EXEC} alu_state_e;
   alu_state_e state;
   logic [4:0] cnt;
   logic [4:0] lastCnt;
   logic [2:0] grp;
   alu_src_e src;
   logic [7:0] immByte;
   logic accSel;
   logic [7:0] regData;
   logic [7:0] operand;
   logic decOk;
   logic decPfx;
   alu_src_e decSrc;
   logic [4:0] decLast;
   logic [2:0] decRead;
   always_comb begin
      decOk = 1'b0;
      decPfx = 1'b0;
      decSrc = ALU_SRC_REG;
      decLast = 5'(ALU_DIR_LAST);
      decRead = opcode[2:0];
      if (prefix == ALU_PFX_FIRST || prefix == ALU_PFX_SECOND) begin
         decPfx = 1'b1;
      end
      // Group code in bits 5:3 selects add, adc, sub, sbc or and.
      if (opcode[5:3] <= ALU_GRP_AND) begin
         if ((opcode & ALU_MEM_MASK) == ALU_MEM_PAT) begin
            decOk = 1'b1;
            if (decPfx) begin
               decSrc = ALU_SRC_IDX;
               decLast = ALU_IDX_LAST;
            end else begin
               decSrc = ALU_SRC_PAIR;
               decLast = 5'(ALU_MEM_LAST);
            end
         end else if ((opcode & ALU_MEM_MASK) == ALU_IMM_PAT && !decPfx) begin
            decOk = 1'b1;
            decSrc = ALU_SRC_IMM;
            decLast = 5'(ALU_MEM_LAST);
         end else if (opcode[7:6] == ALU_REG_TOP && !decPfx) begin
            // Fields 0 to 5 and 7 name registers; 6 is the memory form.
            decOk = 1'b1;
            decSrc = ALU_SRC_REG;
         end
      end
   end
   // ****************************************************************
   // Sequencing
   // ****************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         cnt <= 5'h00;
         lastCnt <= 5'h00;
         grp <= ALU_GRP_ADD;
         src <= ALU_SRC_REG;
         immByte <= 8'h00;
         accSel <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         illegal <= 1'b0;
         memRd <= 1'b0;
         memAddr <= '0;
      end else if (clkEn) begin
         done <= 1'b0;
         illegal <= 1'b0;
         memRd <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (start && decOk) begin
                  state <= ST_WAIT;
                  busy <= 1'b1;
                  cnt <= 5'h01;
                  lastCnt <= decLast;
                  grp <= opcode[5:3];
                  src <= decSrc;
                  immByte <= operandByte;
                  // The accumulator choice is kept so the decoder may move on after the take.
                  accSel <= decSrc == ALU_SRC_REG && opcode[2:0] == ALU_FLD_ACC;
                  if (decSrc == ALU_SRC_PAIR) begin
                     memRd <= 1'b1;
                     memAddr <= address_pair;
                  end else if (decSrc == ALU_SRC_IDX) begin
                     memRd <= 1'b1;
                     // Index plus sign-extended displacement.
                     memAddr <= (prefix == ALU_PFX_SECOND ? second_index_register
                        : first_index_register)
                        + {{(ADDR_W-8){operandByte[7]}}, operandByte};
                  end
               end else if (start) begin
                  illegal <= 1'b1;
               end
            end
            ST_WAIT: begin
               cnt <= cnt + 5'h01;
               if (cnt == lastCnt) begin
                  state <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               state <= ST_IDLE;
               busy <= 1'b0;
               done <= 1'b1;
            end
            default: begin
               state <= ST_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end
   // ****************************************************************
   // Operand registers
   // ****************************************************************
   alu_regfile #(.DEPTH(ALU_NREG)) uRegs (
      .clk(clk),
      .arst_n(arst_n),
      .clkEn(clkEn),
      .wrEn(regWrEn),
      .wrSel(regWrSel),
      .wrData(regWrData),
      .rdSel(decRead),
      .rdData(regData)
   );
   logic [7:0] memByte;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         memByte <= 8'h00;
      end else if (clkEn && state == ST_WAIT && cnt == 5'h01) begin
         memByte <= memData;
      end
   end
   logic [7:0] regHeld;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         regHeld <= 8'h00;
      end else if (clkEn && state == ST_WAIT && cnt == 5'h01) begin
         regHeld <= accSel ? acc : regData;
      end
   end
   always_comb begin
      case (src)
         ALU_SRC_REG: operand = regHeld;
         ALU_SRC_IMM: operand = immByte;
         default: operand = memByte;
      endcase
   end
   // ****************************************************************
   // Arithmetic and flags
   // ****************************************************************
   logic isSub;
   logic cin;
   logic [7:0] opnd;
   logic [8:0] sum;
   logic [4:0] lowSum;
   logic [7:0] res;
   alu_flags_s next_flags;
   always_comb begin
      isSub = (grp == ALU_GRP_SUB || grp == ALU_GRP_SBC);
      // Carry joins only for adc and sbc.
      cin = (grp == ALU_GRP_ADC || grp == ALU_GRP_SBC) ? flags.carry : 1'b0;
      opnd = isSub ? ~operand : operand;
      sum = {1'b0, acc} + {1'b0, opnd} + {8'h00, cin ^ isSub};
      lowSum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin ^ isSub};
      next_flags = ALU_FLAGS_RST;
      if (grp == ALU_GRP_AND) begin
         res = acc & operand;
         next_flags.half = 1'b1;
         next_flags.parOvf = ~^res;
      end else begin
         res = sum[7:0];
         // Borrow is the inverted carry when subtracting.
         next_flags.half = lowSum[4] ^ isSub;
         next_flags.carry = sum[8] ^ isSub;
         next_flags.parOvf = (acc[7] == opnd[7]) && (res[7] != acc[7]);
         next_flags.subtract = isSub;
      end
      next_flags.sign = res[7];
      next_flags.zero = (res == 8'h00);
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc <= ALU_ACC_RST;
         flags <= ALU_FLAGS_RST;
      end else if (clkEn && state == ST_EXEC) begin
         acc <= res;
         flags <= next_flags;
      end
   end
endmodule

//--- test/alu_mem_model.sv
// Memory model for the datapath read port.
// Assumes the byte is sampled at the edge that ends the memRd cycle.
`timescale 1ns/1ps
module alu_mem_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic memRd,
   input wire logic [15:0] memAddr,
   output logic [7:0] memData
);
   logic [7:0] junk;
   // Outside a read the bus carries a value that changes every cycle.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         junk <= 8'h00;
      end else begin
         junk <= junk + 8'h3b;
      end
   end
   assign memData = memRd ? memAddr[7:0] ^ memAddr[15:8] ^ 8'ha5 : junk;
endmodule

//--- test/alu_core_properties.sv
// Checker for the datapath top: latency, addressing and flag relations.
// Assumes clkEn is high while an instruction runs; the bench drops it only between instructions.
`timescale 1ns/1ps
module alu_core_check import alu_pkg::*; #(
   parameter int ADDR_W = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic start,
   input wire logic [7:0] prefix,
   input wire logic [7:0] opcode,
   input wire logic [7:0] operandByte,
   input wire logic [ADDR_W-1:0] address_pair,
   input wire logic [ADDR_W-1:0] first_index_register,
   input wire logic [ADDR_W-1:0] second_index_register,
   input wire logic busy,
   input wire logic done,
   input wire logic illegal,
   input wire logic memRd,
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic [7:0] acc,
   input wire alu_flags_s flags
);
   logic take, px, rgF, imF, mmF, gOk;
   logic [2:0] grp;
   logic [ADDR_W-1:0] expAddr, disp;
   assign take = clkEn && start && !busy;
   assign px = prefix == 8'hdd || prefix == 8'hfd;
   assign gOk = opcode[5:3] <= 3'h4;
   assign rgF = opcode[7:6] == 2'h2 && opcode[2:0] != 3'h6 && gOk && !px;
   assign mmF = opcode[7:6] == 2'h2 && opcode[2:0] == 3'h6 && gOk;
   assign imF = opcode[7:6] == 2'h3 && opcode[2:0] == 3'h6 && gOk && !px;
   assign disp = ADDR_W'({{8{operandByte[7]}}, operandByte});
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         grp <= 3'h0;
         expAddr <= '0;
      end else if (take) begin
         grp <= opcode[5:3];
         expAddr <= prefix == 8'hdd ? first_index_register + disp :
            prefix == 8'hfd ? second_index_register + disp : address_pair;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   AST_DONE_PULSE: assert property (done |=> !done)
      else $error("done too long");
   AST_REG_TIME: assert property (take && rgF |=> busy [*4] ##1 (done && !busy))
      else $error("register form timing");
   AST_SHORT_TIME: assert property (take && (imF || mmF && !px) |-> ##8 done)
      else $error("immediate or pair timing");
   AST_IDX_TIME: assert property (take && mmF && px |-> ##20 done)
      else $error("indexed timing");
   AST_ADDR: assert property (take && mmF |=> memRd && memAddr == expAddr)
      else $error("read address");
   AST_BAD_OP: assert property (take && !(rgF || imF || mmF) |=> illegal && !busy)
      else $error("undecodable not refused");
   AST_AND_FLAGS: assert property (done && grp == 3'h4 |->
      flags.half && !flags.subtract && !flags.carry && flags.parOvf == ~^acc)
      else $error("and flags");
   AST_ARITH_FLAGS: assert property (done && grp != 3'h4 |->
      flags.subtract == grp[1] && flags.sign == acc[7] && flags.zero == (acc == 8'h00))
      else $error("arith flags");
   AST_ACC_AT_DONE: assert property ($changed(acc) || $changed(flags) |-> done)
      else $error("acc moved without done");
endmodule
bind alu_core alu_core_check #(.ADDR_W(ADDR_W)) i_alu_core_check (.clk(clk), .arst_n(arst_n),
   .clkEn(clkEn), .start(start), .prefix(prefix), .opcode(opcode), .operandByte(operandByte),
   .address_pair(address_pair), .first_index_register(first_index_register),
   .second_index_register(second_index_register), .busy(busy), .done(done),
   .illegal(illegal), .memRd(memRd), .memAddr(memAddr), .acc(acc), .flags(flags));

//--- test/alu8_add_sub_and_flags_test.sv
// Bench for the datapath: random instructions checked against a reference model.
// Assumes the memory model and checker are compiled with it.
`timescale 1ns/1ps
module alu8_add_sub_and_flags_test import alu_pkg::*;;
   logic clk = 1'b0, arst_n = 1'b0, clkEn = 1'b1, start = 1'b0, regWrEn = 1'b0;
   logic [7:0] prefix = 8'h00, opcode = 8'h00, operandByte = 8'h00, regWrData = 8'h00;
   logic [7:0] memData, acc, mAcc = 8'h00, rf [8];
   logic [2:0] regWrSel = 3'h0;
   logic [15:0] pairAdr = 16'h0000, idx1 = 16'h0000, idx2 = 16'h0000, memAddr;
   logic busy, done, illegal, memRd;
   alu_flags_s flags, mF = ALU_FLAGS_RST;
   int err_total = 0, n_tests = 0, seed = 32'h72de5ba1, x;
   alu_core i_alu_core (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .start(start),
      .prefix(prefix), .opcode(opcode), .operandByte(operandByte), .address_pair(pairAdr),
      .first_index_register(idx1), .second_index_register(idx2), .memData(memData),
      .regWrEn(regWrEn), .regWrSel(regWrSel), .regWrData(regWrData), .busy(busy),
      .done(done), .illegal(illegal), .memRd(memRd), .memAddr(memAddr), .acc(acc),
      .flags(flags));
   alu_mem_model i_alu_mem_model (.clk(clk), .arst_n(arst_n), .memRd(memRd),
      .memAddr(memAddr), .memData(memData));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk8(input logic [7:0] g, e, input string m);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, e, input string m);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: %s got %b exp %b", $time, m, g, e);
      end
   endtask
   task automatic chk_flags(input alu_flags_s g, e, input string m);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic run(input logic [7:0] p, op, d);
      logic [7:0] b, r;
      logic [15:0] ad;
      logic rg, im, mm, px, ok, hf, vf, cf;
      int s, ci, n, k;
      alu_flags_s ef;
      rg = op[7:6] == 2'h2 && op[2:0] != 3'h6;
      im = op[7:6] == 2'h3 && op[2:0] == 3'h6;
      mm = op[7:6] == 2'h2 && op[2:0] == 3'h6;
      px = p == 8'hdd || p == 8'hfd;
      ok = op[5:3] <= 3'h4 && (mm || !px && (rg || im));
      ad = p == 8'hdd ? idx1 + {{8{d[7]}}, d} : p == 8'hfd ? idx2 + {{8{d[7]}}, d} : pairAdr;
      b = rg ? (op[2:0] == 3'h7 ? mAcc : rf[op[2:0]]) : im ? d : ad[7:0] ^ ad[15:8] ^ 8'ha5;
      ci = op[3] ? int'(mF.carry) : 0;
      k = rg ? 5 : mm && px ? 20 : 8;
      if (op[5:4] == 2'h0) begin
         s = mAcc + b + ci;
         hf = mAcc[3:0] + b[3:0] + ci > 15;
         vf = mAcc[7] == b[7] && s[7] != mAcc[7];
         cf = s > 255;
      end else begin
         s = mAcc - b - ci;
         hf = int'(mAcc[3:0]) < int'(b[3:0]) + ci;
         vf = mAcc[7] != b[7] && s[7] != mAcc[7];
         cf = s < 0;
      end
      r = op[5] ? mAcc & b : s[7:0];
      ef = '{r[7], r == 8'h00, op[5] | hf, op[5] ? ~^r : vf, op[4] & !op[5], cf & !op[5]};
      @(negedge clk);
      prefix = p;
      opcode = op;
      operandByte = d;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      n = 1;
      if (!ok) begin
         chk_bit(illegal, 1'b1, "refusal");
         return;
      end
      while (done !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
         start = n == 2;
      end
      chk8(8'(n), 8'(k), "cycles");
      chk8(acc, r, "acc");
      chk_flags(flags, ef, "flags");
      mAcc = r;
      mF = ef;
   endtask
   initial begin
      #300000;
      err_total++;
      give_verdict();
   end
   initial begin
      for (int i = 0; i < 8; i++) rf[i] = 8'h00;
      repeat (20) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      for (int i = 0; i < 300; i++) begin
         x = $random(seed);
         regWrSel = x[2:0];
         regWrData = x[10:3];
         pairAdr = 16'($random(seed));
         idx1 = 16'($random(seed));
         idx2 = 16'($random(seed));
         regWrEn = 1'b1;
         rf[regWrSel] = regWrData;
         @(negedge clk);
         // A write offered while the clock enable is low must not land.
         clkEn = 1'b0;
         regWrSel = x[13:11];
         regWrData = x[21:14];
         @(negedge clk);
         clkEn = 1'b1;
         regWrEn = 1'b0;
         x = $random(seed);
         run(x[9] ? 8'hfd : x[8] ? 8'hdd : 8'h00, {1'b1, x[6], x[12] ? x[5:3] : {1'b0, x[4:3]},
            x[11] ? 3'h6 : x[2:0]}, x[20:13]);
      end
      $display("random instruction test done");
      give_verdict();
   end
endmodule
